// file: pkg/circ_addr_pkg.sv
// Constants and types for the circular-buffer address correction block.
// Shared by the correction top and its per-generator corrector.
package circ_addr_pkg;
    // Register byte offsets on the plain register port
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_X_START = 8'h04;
    localparam logic [7:0] OFF_X_END = 8'h08;
    localparam logic [7:0] OFF_Y_START = 8'h0C;
    localparam logic [7:0] OFF_Y_END = 8'h10;
    localparam logic [7:0] OFF_BITREV = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // Field positions of circular_addr_control, plus the enable bit of bitrev_control
    localparam int X_SEL_LSB = 0;
    localparam int Y_SEL_LSB = 4;
    localparam int BR_SEL_LSB = 8;
    localparam int Y_EN_BIT = 14;
    localparam int X_EN_BIT = 15;
    localparam int BITREV_EN_BIT = 15;

    // Register writable masks (unused bits read as zero)
    localparam logic [15:0] CONTROL_MASK = 16'hCFFF;
    localparam logic [15:0] BITREV_MASK = 16'h8000;

    // Reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] BOUND_RESET = 16'h0000;
    localparam logic [15:0] BITREV_RESET = 16'h0000;
    localparam logic [2:0] STATUS_RESET = 3'h0;

    // Pointer selector value that disables a space
    localparam logic [3:0] SEL_NONE = 4'hF;

    // Generator indices
    localparam int GEN_XR = 0;
    localparam int GEN_XW = 1;
    localparam int GEN_Y = 2;
    localparam int NUM_GEN = 3;

    typedef enum logic [1:0] {
        AM_PLAIN,
        AM_PRE_MOD,
        AM_POST_MOD,
        AM_REG_OFFSET
    } addr_mode_t;
endpackage

// file: rtl/circ_corrector.sv
// Combinational boundary check and correction for one address generator.
// Assumes bounds are stable while an address is presented.
`timescale 1ns/1ps
module circ_corrector (
    input wire logic active_in,
    input wire logic dec_in,
    input wire logic word_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] start_in,
    input wire logic [15:0] end_in,
    output logic [15:0] addr_out,
    output logic hit_out
);
    import circ_addr_pkg::*;

    logic [16:0] len;
    logic pow2;
    logic above;
    logic below;
    logic [16:0] sum;

    always_comb begin
        // Length comes from the bounds alone
        len = {1'b0, end_in} - {1'b0, start_in} + 17'h0_0001;
        pow2 = ((len & (len - 17'h0_0001)) == 17'h0_0000);
        // Magnitude compares, so jumps past a bound still correct
        above = (addr_in > end_in);
        below = (addr_in < start_in);
        hit_out = 1'b0;
        sum = {1'b0, addr_in};
        if (active_in) begin
            // Power-of-two buffers check both bounds
            if (above && (!dec_in || pow2)) begin
                // Other lengths: incrementing corrects at the upper bound only
                hit_out = 1'b1;
                sum = {1'b0, addr_in} - len;
            end else if (below && (dec_in || pow2)) begin
                hit_out = 1'b1;
                sum = {1'b0, addr_in} + len;
            end
        end
        addr_out = sum[15:0];
        // Word-only generator clears bit 0 while its correction is active
        if (word_in && active_in) begin
            addr_out[0] = 1'b0;
        end
    end
endmodule

// file: rtl/circ_addr_correct.sv
// Circular-buffer correction of X read, X write and Y effective addresses.
// Assumes the datapath presents one address per generator per cycle on
// clk_sys_in and takes the corrected address one cycle later.
// Register writes to unmapped offsets are dropped; unmapped reads give zero.
// Behaviour
// - One circular buffer in X space (also program space) and one in Y.
// - Offset sign picks incrementing or decrementing treatment.
// - Power-of-two length buffers are checked at both bounds.
// - Each space has 16-bit start and end byte-address bound registers.
// - Y generator assumes word data and clears address bit 0 when Y correction is active.
// - Length is end minus start plus one, up to 32K words.
// - X active when enable bit 15 set and select bits 3:0 not 15.
// - Y active when enable bit 14 set and select bits 7:4 not 15.
// - X read and write share bounds and pointer select.
// - Bound checks are magnitude compares, not equality.
// - Only pre or post modified addressing is corrected.
// - Other lengths: incrementing fixes upper bound only; decrementing lower only.
// - Bit-reversal wins over circular in X write; X read unaffected.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module circ_addr_correct (
    // Clock, reset and register port
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // X read generator
    input wire logic xr_valid_in,
    input wire logic [3:0] xr_ptr_in,
    input wire circ_addr_pkg::addr_mode_t xr_mode_in,
    input wire logic xr_dec_in,
    input wire logic [15:0] xr_addr_in,
    output logic xr_valid_out,
    output logic [15:0] xr_addr_out,
    output logic xr_corrected_out,
    // X write generator
    input wire logic xw_valid_in,
    input wire logic [3:0] xw_ptr_in,
    input wire circ_addr_pkg::addr_mode_t xw_mode_in,
    input wire logic xw_dec_in,
    input wire logic [15:0] xw_addr_in,
    output logic xw_valid_out,
    output logic [15:0] xw_addr_out,
    output logic xw_corrected_out,
    output logic xw_bitrev_out,
    // Y generator
    input wire logic y_valid_in,
    input wire logic [3:0] y_ptr_in,
    input wire circ_addr_pkg::addr_mode_t y_mode_in,
    input wire logic y_dec_in,
    input wire logic [15:0] y_addr_in,
    output logic y_valid_out,
    output logic [15:0] y_addr_out,
    output logic y_corrected_out
);
    import circ_addr_pkg::*;

    // Register file
    logic [15:0] circular_addr_control;
    logic [15:0] x_buffer_start_bound;
    logic [15:0] x_buffer_end_bound;
    logic [15:0] y_buffer_start_bound;
    logic [15:0] y_buffer_end_bound;
    logic [15:0] bitrev_control;
    logic [2:0] corr_seen;
    logic [15:0] next_circular_addr_control;
    logic [15:0] next_x_buffer_start_bound;
    logic [15:0] next_x_buffer_end_bound;
    logic [15:0] next_y_buffer_start_bound;
    logic [15:0] next_y_buffer_end_bound;
    logic [15:0] next_bitrev_control;
    logic [2:0] next_corr_seen;
    logic [15:0] next_reg_rdata;

    // Control fields
    logic [3:0] x_pointer_select;
    logic [3:0] y_pointer_select;
    logic [3:0] bitrev_pointer_select;
    logic x_circular_enable;
    logic y_circular_enable;
    logic x_space_on;
    logic y_space_on;
    logic bitrev_active;
    logic bitrev_enable;
    logic bitrev_select_ok;
    logic bitrev_mode_ok;
    logic bitrev_ptr_hit;
    logic wr_status;

    // Per-generator views
    logic [NUM_GEN-1:0] g_valid;
    logic [NUM_GEN-1:0] g_dec;
    logic [NUM_GEN-1:0] g_active;
    logic [NUM_GEN-1:0] g_hit;
    logic [3:0] g_ptr [NUM_GEN];
    addr_mode_t g_mode [NUM_GEN];
    logic [15:0] g_addr [NUM_GEN];
    logic [15:0] g_fixed [NUM_GEN];

    // Output stage
    logic [NUM_GEN-1:0] out_valid;
    logic [NUM_GEN-1:0] out_hit;
    logic [15:0] out_addr [NUM_GEN];
    logic out_bitrev;
    logic [NUM_GEN-1:0] next_out_valid;
    logic [NUM_GEN-1:0] next_out_hit;
    logic [15:0] next_out_addr [NUM_GEN];
    logic next_out_bitrev;

    assign x_pointer_select = circular_addr_control[X_SEL_LSB +: 4];
    assign y_pointer_select = circular_addr_control[Y_SEL_LSB +: 4];
    assign bitrev_pointer_select = circular_addr_control[BR_SEL_LSB +: 4];
    assign x_circular_enable = circular_addr_control[X_EN_BIT];
    assign y_circular_enable = circular_addr_control[Y_EN_BIT];

    // One enable and one selector for the X read and write side
    assign x_space_on = x_circular_enable && (x_pointer_select != SEL_NONE);
    assign y_space_on = y_circular_enable && (y_pointer_select != SEL_NONE);

    // Bit-reversal only acts on post-increment writes
    assign bitrev_enable = bitrev_control[BITREV_EN_BIT];
    assign bitrev_select_ok = (bitrev_pointer_select != SEL_NONE);
    assign bitrev_mode_ok = (xw_mode_in == AM_POST_MOD) && !xw_dec_in;
    assign bitrev_ptr_hit = (xw_ptr_in == bitrev_pointer_select);
    assign bitrev_active = bitrev_enable && bitrev_select_ok && bitrev_mode_ok && bitrev_ptr_hit;

    // Indexed views so the per-generator logic is one loop
    assign g_valid = {y_valid_in, xw_valid_in, xr_valid_in};
    assign g_dec = {y_dec_in, xw_dec_in, xr_dec_in};
    assign g_ptr[GEN_XR] = xr_ptr_in;
    assign g_ptr[GEN_XW] = xw_ptr_in;
    assign g_ptr[GEN_Y] = y_ptr_in;
    assign g_mode[GEN_XR] = xr_mode_in;
    assign g_mode[GEN_XW] = xw_mode_in;
    assign g_mode[GEN_Y] = y_mode_in;
    assign g_addr[GEN_XR] = xr_addr_in;
    assign g_addr[GEN_XW] = xw_addr_in;
    assign g_addr[GEN_Y] = y_addr_in;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_GEN; gi++) begin : gen_corr
            // X read and X write share the X bounds; Y has its own
            localparam bit IS_Y = (gi == GEN_Y);
            localparam bit IS_XW = (gi == GEN_XW);
            logic sel_ok;
            logic mode_ok;
            assign sel_ok = IS_Y ? (y_space_on && (g_ptr[gi] == y_pointer_select))
                : (x_space_on && (g_ptr[gi] == x_pointer_select));
            // Indexed addressing passes through
            assign mode_ok = (g_mode[gi] == AM_PRE_MOD) || (g_mode[gi] == AM_POST_MOD);
            // Bit-reversal overrides circular only on the X write side
            assign g_active[gi] = g_valid[gi] && sel_ok && mode_ok && !(IS_XW && bitrev_active);
            circ_corrector u_corr (
                .active_in(g_active[gi]),
                .dec_in(g_dec[gi]),
                .word_in(IS_Y),
                .addr_in(g_addr[gi]),
                .start_in(IS_Y ? y_buffer_start_bound : x_buffer_start_bound),
                .end_in(IS_Y ? y_buffer_end_bound : x_buffer_end_bound),
                .addr_out(g_fixed[gi]),
                .hit_out(g_hit[gi])
            );
        end
    endgenerate

    // Configuration registers; unmapped writes change nothing
    always_comb begin
        next_circular_addr_control = circular_addr_control;
        next_x_buffer_start_bound = x_buffer_start_bound;
        next_x_buffer_end_bound = x_buffer_end_bound;
        next_y_buffer_start_bound = y_buffer_start_bound;
        next_y_buffer_end_bound = y_buffer_end_bound;
        next_bitrev_control = bitrev_control;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFF_CONTROL: next_circular_addr_control = reg_wdata_in & CONTROL_MASK;
                // Bounds are full 16-bit byte addresses
                OFF_X_START: next_x_buffer_start_bound = reg_wdata_in;
                OFF_X_END: next_x_buffer_end_bound = reg_wdata_in;
                OFF_Y_START: next_y_buffer_start_bound = reg_wdata_in;
                OFF_Y_END: next_y_buffer_end_bound = reg_wdata_in;
                OFF_BITREV: next_bitrev_control = reg_wdata_in & BITREV_MASK;
                default: next_bitrev_control = bitrev_control;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            circular_addr_control <= CONTROL_RESET;
            x_buffer_start_bound <= BOUND_RESET;
            x_buffer_end_bound <= BOUND_RESET;
            y_buffer_start_bound <= BOUND_RESET;
            y_buffer_end_bound <= BOUND_RESET;
            bitrev_control <= BITREV_RESET;
        end else begin
            circular_addr_control <= next_circular_addr_control;
            x_buffer_start_bound <= next_x_buffer_start_bound;
            x_buffer_end_bound <= next_x_buffer_end_bound;
            y_buffer_start_bound <= next_y_buffer_start_bound;
            y_buffer_end_bound <= next_y_buffer_end_bound;
            bitrev_control <= next_bitrev_control;
        end
    end

    // Sticky correction flags, one per generator, write one to clear
    assign wr_status = reg_wr_in && (reg_addr_in == OFF_STATUS);

    always_comb begin
        next_corr_seen = corr_seen;
        if (wr_status) begin
            next_corr_seen = corr_seen & ~reg_wdata_in[2:0];
        end
        // Set wins: a correction in the clearing cycle is kept
        next_corr_seen = next_corr_seen | g_hit;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            corr_seen <= STATUS_RESET;
        end else begin
            corr_seen <= next_corr_seen;
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always_comb begin
        next_reg_rdata = 16'h0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFF_CONTROL: next_reg_rdata = circular_addr_control;
                OFF_X_START: next_reg_rdata = x_buffer_start_bound;
                OFF_X_END: next_reg_rdata = x_buffer_end_bound;
                OFF_Y_START: next_reg_rdata = y_buffer_start_bound;
                OFF_Y_END: next_reg_rdata = y_buffer_end_bound;
                OFF_BITREV: next_reg_rdata = bitrev_control;
                OFF_STATUS: next_reg_rdata = {13'h0000, corr_seen};
                default: next_reg_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= next_reg_rdata;
        end
    end

    // Strobes stand for one cycle per request
    always_comb begin
        next_out_valid = g_valid;
        next_out_hit = g_hit;
        next_out_bitrev = xw_valid_in && bitrev_active;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            out_valid <= 3'h0;
            out_hit <= 3'h0;
            out_bitrev <= 1'b0;
        end else begin
            out_valid <= next_out_valid;
            out_hit <= next_out_hit;
            out_bitrev <= next_out_bitrev;
        end
    end

    // Idle generators hold their last address
    always_comb begin
        for (int i = 0; i < NUM_GEN; i++) begin
            next_out_addr[i] = g_valid[i] ? g_fixed[i] : out_addr[i];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_GEN; i++) begin
                out_addr[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < NUM_GEN; i++) begin
                out_addr[i] <= next_out_addr[i];
            end
        end
    end

    assign xr_valid_out = out_valid[GEN_XR];
    assign xr_addr_out = out_addr[GEN_XR];
    assign xr_corrected_out = out_hit[GEN_XR];
    assign xw_valid_out = out_valid[GEN_XW];
    assign xw_addr_out = out_addr[GEN_XW];
    assign xw_corrected_out = out_hit[GEN_XW];
    assign xw_bitrev_out = out_bitrev;
    assign y_valid_out = out_valid[GEN_Y];
    assign y_addr_out = out_addr[GEN_Y];
    assign y_corrected_out = out_hit[GEN_Y];
endmodule

// file: verif/circ_addr_chk.sv
// Port assertions for circ_addr_correct.
// Assumes one clock domain; control is shadowed from register writes.
`timescale 1ns/1ps
module circ_addr_chk (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic xr_valid_in,
    input wire circ_addr_pkg::addr_mode_t xr_mode_in,
    input wire logic [15:0] xr_addr_in,
    input wire logic [15:0] xr_addr_out,
    input wire logic xr_corrected_out,
    input wire logic xw_corrected_out,
    input wire logic xw_bitrev_out,
    input wire logic y_valid_in,
    input wire logic [15:0] y_addr_out,
    input wire logic y_corrected_out
);
    import circ_addr_pkg::*;
    logic [15:0] ctl;
    logic [15:0] next_ctl;
    always_comb begin
        next_ctl = ctl;
        if (reg_wr_in && reg_addr_in == OFF_CONTROL) begin
            next_ctl = reg_wdata_in & CONTROL_MASK;
        end
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctl <= CONTROL_RESET;
        end else begin
            ctl <= next_ctl;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_xr_req;
        xr_valid_in;
    endsequence
    sequence s_xr_plain;
        xr_valid_in && (xr_mode_in == AM_PLAIN || xr_mode_in == AM_REG_OFFSET);
    endsequence
    property p_xr_plain;
        s_xr_plain |=> !xr_corrected_out && xr_addr_out == $past(xr_addr_in);
    endproperty
    a_xr_plain: assert property (p_xr_plain) else $error("plain xr address altered");
    property p_corr_moves;
        s_xr_req ##1 xr_corrected_out |-> xr_addr_out != $past(xr_addr_in);
    endproperty
    a_corr_moves: assert property (p_corr_moves) else $error("xr corrected, same addr");
    property p_x_off;
        xr_valid_in && (!ctl[X_EN_BIT] || ctl[3:0] == SEL_NONE)
            |=> !xr_corrected_out && xr_addr_out == $past(xr_addr_in);
    endproperty
    a_x_off: assert property (p_x_off) else $error("xr corrected while off");
    property p_y_off;
        y_valid_in && (!ctl[Y_EN_BIT] || ctl[7:4] == SEL_NONE) |=> !y_corrected_out;
    endproperty
    a_y_off: assert property (p_y_off) else $error("y corrected while off");
    property p_bitrev;
        xw_bitrev_out |-> !xw_corrected_out;
    endproperty
    a_bitrev: assert property (p_bitrev) else $error("xw corrected under bitrev");
    property p_y_word;
        y_corrected_out |-> !y_addr_out[0];
    endproperty
    a_y_word: assert property (p_y_word) else $error("y address odd");
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_ctrl_rd;
        reg_rd_in && reg_addr_in == OFF_CONTROL |=> reg_rdata_out == ctl;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
endmodule
bind circ_addr_correct circ_addr_chk i_chk (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .xr_valid_in, .xr_mode_in, .xr_addr_in,
    .xr_addr_out, .xr_corrected_out, .xw_corrected_out, .xw_bitrev_out, .y_valid_in,
    .y_addr_out, .y_corrected_out);

// file: verif/datapath_model.sv
// Model of the execution datapath feeding all three generators.
// Presents one request the cycle after go_in.
`timescale 1ns/1ps
module datapath_model (
    input wire logic clk_sys_in,
    input wire logic go_in,
    input wire logic [3:0] ptr_in,
    input wire circ_addr_pkg::addr_mode_t mode_in,
    input wire logic dec_in,
    input wire logic [15:0] addr_in,
    output logic valid_out,
    output logic [3:0] ptr_out,
    output circ_addr_pkg::addr_mode_t mode_out,
    output logic dec_out,
    output logic [15:0] addr_out
);
    import circ_addr_pkg::*;
    initial begin
        valid_out = 1'b0;
        ptr_out = 4'h0;
        mode_out = AM_PLAIN;
        dec_out = 1'b0;
        addr_out = 16'h0000;
    end
    // Idle address toggles so sampling without valid shows up
    always @(posedge clk_sys_in) begin
        valid_out <= go_in;
        if (go_in) begin
            ptr_out <= ptr_in;
            mode_out <= mode_in;
            dec_out <= dec_in;
            addr_out <= addr_in;
        end else begin
            addr_out <= ~addr_out;
        end
    end
endmodule

// file: verif/circular_buffer_address_correction_bench.sv
// Self-checking bench for circ_addr_correct with a datapath model.
// Assumes the package register offsets and one-cycle answers.
`timescale 1ns/1ps
module circular_buffer_address_correction_bench;
    import circ_addr_pkg::*;
    typedef struct packed {
        logic [3:0] ptr;
        addr_mode_t mode;
        logic dec;
        logic [15:0] addr;
        logic [15:0] exp;
        logic corr;
    } row_t;
    // Buffer 0x2000..0x2063, 100 bytes, not a power of two
    row_t rows [0:10] = '{
        '{4'h3, AM_POST_MOD, 1'b0, 16'h2064, 16'h2000, 1'b1},
        '{4'h3, AM_PRE_MOD, 1'b0, 16'h2070, 16'h200C, 1'b1},
        '{4'h3, AM_POST_MOD, 1'b0, 16'h2062, 16'h2062, 1'b0},
        '{4'h3, AM_REG_OFFSET, 1'b0, 16'h2064, 16'h2064, 1'b0},
        '{4'h3, AM_PLAIN, 1'b0, 16'h2064, 16'h2064, 1'b0},
        '{4'h3, AM_POST_MOD, 1'b1, 16'h1FFE, 16'h2062, 1'b1},
        '{4'h3, AM_PRE_MOD, 1'b1, 16'h1FF0, 16'h2054, 1'b1},
        '{4'h3, AM_POST_MOD, 1'b0, 16'h1FFE, 16'h1FFE, 1'b0},
        '{4'h3, AM_POST_MOD, 1'b1, 16'h2066, 16'h2066, 1'b0},
        '{4'h4, AM_POST_MOD, 1'b0, 16'h2064, 16'h2064, 1'b0},
        '{4'h3, AM_POST_MOD, 1'b0, 16'h2065, 16'h2001, 1'b1}
    };
    logic [15:0] ctl_v [0:3] = '{16'h4F33, 16'hCF3F, 16'h8F33, 16'hCFF3};
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic go = 1'b0;
    logic [3:0] ptr = 4'h0;
    addr_mode_t mode = AM_PLAIN;
    logic dec = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic valid, d_dec, act;
    logic [3:0] d_ptr;
    addr_mode_t d_mode;
    logic [15:0] d_addr, reg_rdata_out, xr_addr_out, xw_addr_out, y_addr_out;
    logic xr_valid_out, xr_corrected_out, xw_valid_out, xw_corrected_out, xw_bitrev_out;
    logic y_valid_out, y_corrected_out;
    wire logic [5:0] flags = {xr_valid_out, xw_valid_out, y_valid_out, xr_corrected_out,
        xw_corrected_out, y_corrected_out};
    int checks = 0;
    int n_errors = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    datapath_model i_model (.clk_sys_in, .go_in(go), .ptr_in(ptr), .mode_in(mode), .dec_in(dec),
        .addr_in(addr), .valid_out(valid), .ptr_out(d_ptr), .mode_out(d_mode), .dec_out(d_dec),
        .addr_out(d_addr));
    circ_addr_correct i_circ_addr_correct (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .xr_valid_in(valid), .xr_ptr_in(d_ptr),
        .xr_mode_in(d_mode), .xr_dec_in(d_dec), .xr_addr_in(d_addr), .xr_valid_out,
        .xr_addr_out, .xr_corrected_out, .xw_valid_in(valid), .xw_ptr_in(d_ptr),
        .xw_mode_in(d_mode), .xw_dec_in(d_dec), .xw_addr_in(d_addr), .xw_valid_out,
        .xw_addr_out, .xw_corrected_out, .xw_bitrev_out, .y_valid_in(valid), .y_ptr_in(d_ptr),
        .y_mode_in(d_mode), .y_dec_in(d_dec), .y_addr_in(d_addr), .y_valid_out, .y_addr_out,
        .y_corrected_out);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, exp);
    endtask
    task automatic req(input logic [3:0] p, input addr_mode_t m, input logic d,
        input logic [15:0] a);
        @(posedge clk_sys_in);
        go <= 1'b1;
        ptr <= p;
        mode <= m;
        dec <= d;
        addr <= a;
        @(posedge clk_sys_in);
        go <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        check({10'h000, flags}, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), 16'h0000);
        end
        wr(OFF_CONTROL, 16'hFFFF);
        rd(OFF_CONTROL, CONTROL_MASK);
        wr(8'h1C, 16'hFFFF);
        rd(8'h1C, 16'h0000);
        wr(OFF_X_START, 16'h2000);
        wr(OFF_X_END, 16'h2063);
        wr(OFF_Y_START, 16'h2000);
        wr(OFF_Y_END, 16'h2063);
        wr(OFF_CONTROL, 16'hCF33);
        rd(OFF_X_END, 16'h2063);
        for (int i = 0; i < 11; i++) begin
            req(rows[i].ptr, rows[i].mode, rows[i].dec, rows[i].addr);
            act = rows[i].ptr == 4'h3 && rows[i].mode inside {AM_PRE_MOD, AM_POST_MOD};
            check(xr_addr_out, rows[i].exp);
            check(xw_addr_out, rows[i].exp);
            check(y_addr_out, act ? {rows[i].exp[15:1], 1'b0} : rows[i].exp);
            check({10'h000, flags}, {10'h000, 3'b111, {3{rows[i].corr}}});
        end
        rd(OFF_STATUS, 16'h0007);
        wr(OFF_STATUS, 16'h0007);
        rd(OFF_STATUS, 16'h0000);
        // Shrink to 64 bytes so both bounds are checked
        wr(OFF_X_END, 16'h203F);
        wr(OFF_Y_END, 16'h203F);
        req(4'h3, AM_POST_MOD, 1'b0, 16'h1FFE);
        check(xr_addr_out, 16'h203E);
        req(4'h3, AM_PRE_MOD, 1'b1, 16'h2042);
        check(xr_addr_out, 16'h2002);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CONTROL, ctl_v[i]);
            req(4'h3, AM_POST_MOD, 1'b0, 16'h2064);
            check(xr_addr_out, i < 2 ? 16'h2064 : 16'h2024);
            check(y_addr_out, i < 2 ? 16'h2024 : 16'h2064);
        end
        wr(OFF_BITREV, 16'h8000);
        wr(OFF_CONTROL, 16'hC333);
        req(4'h3, AM_POST_MOD, 1'b0, 16'h2064);
        check(xr_addr_out, 16'h2024);
        check(xw_addr_out, 16'h2064);
        check({12'h000, xw_bitrev_out, xw_corrected_out, 2'b00}, 16'h0008);
        req(4'h3, AM_POST_MOD, 1'b1, 16'h1FFE);
        check(xw_addr_out, 16'h203E);
        // Mid-run reset must clear registers and output strobes
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        check({10'h000, flags}, 16'h0000);
        rd(OFF_BITREV, BITREV_RESET);
        rd(OFF_X_END, BOUND_RESET);
        final_report;
    end
    initial begin
        #2000000;
        n_errors++;
        final_report;
    end
endmodule
